// ### hdl/polarity_ramp.sv
// soft polarity reversal ramp generator
`timescale 1ns/1ps
module polarity_ramp (
   input wire logic ref_clk,
   input wire logic reset_n,
   polarity_ramp_if.gen ramp
);

   logic [slic_ctrl_pkg::RAMP_W-1:0] level_q;
   logic [slic_ctrl_pkg::RAMP_W-1:0] level_d;
   logic [slic_ctrl_pkg::RAMP_STEP_W-1:0] step_q;
   logic [slic_ctrl_pkg::RAMP_STEP_W-1:0] step_d;
   logic settled_q;
   wire logic [slic_ctrl_pkg::RAMP_W-1:0] goal;
   wire logic step_due;
   wire logic at_goal;

   // ---------------------------------------------------------------
   // ramp stepping
   // ---------------------------------------------------------------
   // a step rather than a jump keeps the wire exchange gentle
   assign goal = ramp.target_reversed ? slic_ctrl_pkg::RAMP_REVERSED
                                      : slic_ctrl_pkg::RAMP_NORMAL;
   assign at_goal = (level_q == goal);
   assign step_due = (step_q ==
      slic_ctrl_pkg::RAMP_STEP_W'(slic_ctrl_pkg::RAMP_STEP_CYCLES - 1));
   assign step_d = (at_goal || step_due) ? '0 : step_q + 1'b1;
   assign level_d = (at_goal || !step_due) ? level_q :
                    (level_q < goal) ? level_q + 1'b1 : level_q - 1'b1;

   // ramp state
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         level_q <= slic_ctrl_pkg::RAMP_NORMAL;
         step_q <= '0;
         settled_q <= 1'b1;
      end else begin
         level_q <= level_d;
         step_q <= step_d;
         settled_q <= (level_d == goal);
      end
   end

   assign ramp.level = level_q;
   assign ramp.settled = settled_q;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   a_ramp_single_step: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      (level_q != $past(level_q)) |->
         ((level_q - $past(level_q)) == 8'h01 || ($past(level_q) - level_q) == 8'h01))
      else $error("polarity ramp moved by more than one step");

endmodule // polarity_ramp

// ### hdl/polarity_ramp_if.sv
// interface between the mode decoder and the polarity ramp generator
`timescale 1ns/1ps
interface polarity_ramp_if;
   logic target_reversed;
   logic [slic_ctrl_pkg::RAMP_W-1:0] level;
   logic settled;

   modport ctrl (output target_reversed, input level, input settled);
   modport gen (input target_reversed, output level, output settled);
endinterface

// ### hdl/slic_ctrl_pkg.sv
// constants and types shared by the line-interface control logic
package slic_ctrl_pkg;

   // ---------------------------------------------------------------
   // operating modes
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_POWER_DOWN,
      MODE_HIGH_IMPEDANCE_FEED,
      MODE_ACTIVE,
      MODE_RING
   } op_mode_t;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int REF_CLK_KHZ = 25000;
   localparam int CONV_CLK_KHZ = 125;
   // internal oscillator half period, in ref_clk cycles
   localparam int OSC_HALF_CYCLES = REF_CLK_KHZ / (2 * CONV_CLK_KHZ);
   localparam int OSC_CNT_W = 8;

   // ---------------------------------------------------------------
   // polarity reversal ramp
   // ---------------------------------------------------------------
   localparam int RAMP_W = 8;
   localparam logic [RAMP_W-1:0] RAMP_NORMAL = 8'h00;
   localparam logic [RAMP_W-1:0] RAMP_REVERSED = 8'hFF;
   // cycles per ramp step; stands in for the external ramp capacitor
   localparam int RAMP_STEP_CYCLES = 4;
   localparam int RAMP_STEP_W = 4;

endpackage

// ### hdl/slic_mode_control.sv
// mode decoder, supervision and converter control of the line interface
// What this block does
// - power-down low with both mode bits low gives power down; high gives high-impedance.
// - feed bit high gives active; metering bit adds metering, polarity bit reverses.
// - shutdown high, metering high, feed low gives ringing; controller toggles polarity.
// - loop status goes out on an active-low open-drain detect pin.
// - in high-impedance feed, off-hook pulls detect low at the active threshold.
// - power down opens line terminals, disables detectors and transmission.
// - overtemperature forces power down; previous mode returns below hysteresis.
// - converter gate switches in step with the supplied converter clock.
// - clock pin tied to supply selects the internal oscillator instead.
// - polarity changes in active mode follow a ramp, not a step.
// - ringing mode raises the generated battery to the higher ringing level.
// - clock pin tied to ground disables the converter gate drive.
// - ring trip pulls detect low; controller then stops toggling and picks a mode.
`timescale 1ns/1ps
module slic_mode_control (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic line_shutdown_n,
   input wire logic metering_enable_sel,
   input wire logic feed_enable_sel,
   input wire logic polarity_sel,
   input wire logic off_hook_sense,
   input wire logic ring_trip_sense,
   input wire logic over_temp,
   input wire logic below_hysteresis,
   input wire logic conv_clk_in,
   input wire logic clk_tied_supply,
   input wire logic clk_tied_ground,
   input wire logic battery_low,
   output logic loop_detect_n_o,
   output logic loop_detect_n_oe,
   output slic_ctrl_pkg::op_mode_t op_mode,
   output logic line_terminals_hiz,
   output logic transmission_en,
   output logic metering_pulse,
   output logic ring_battery_sel,
   output logic [slic_ctrl_pkg::RAMP_W-1:0] polarity_level,
   output logic polarity_settled,
   output logic thermal_shutdown,
   output logic gate_drive
);

   // ---------------------------------------------------------------
   // mode decode
   // ---------------------------------------------------------------
   // unlisted combination (shutdown low, metering high, feed low) falls to power down
   function automatic slic_ctrl_pkg::op_mode_t decode_mode(input logic sd_n,
                                                           input logic met,
                                                           input logic feed);
      slic_ctrl_pkg::op_mode_t m;
      m = slic_ctrl_pkg::MODE_POWER_DOWN;
      if (feed) begin
         m = slic_ctrl_pkg::MODE_ACTIVE;
      end else if (sd_n && met) begin
         m = slic_ctrl_pkg::MODE_RING;
      end else if (sd_n) begin
         m = slic_ctrl_pkg::MODE_HIGH_IMPEDANCE_FEED;
      end
      return m;
   endfunction

   slic_ctrl_pkg::op_mode_t mode_q;
   slic_ctrl_pkg::op_mode_t mode_d;
   slic_ctrl_pkg::op_mode_t pin_mode;
   logic thermal_q;
   logic thermal_d;

   // selected mode is decoded live from the pins, so resuming needs no saved copy
   assign pin_mode = decode_mode(line_shutdown_n, metering_enable_sel, feed_enable_sel);
   assign thermal_d = over_temp | (thermal_q & ~below_hysteresis);
   assign mode_d = thermal_d ? slic_ctrl_pkg::MODE_POWER_DOWN : pin_mode;

   // ---------------------------------------------------------------
   // supervision
   // ---------------------------------------------------------------
   logic detect_oe_q;
   logic detect_oe_d;
   logic line_hiz_q;
   logic tx_en_q;
   logic metering_q;
   logic ring_bat_q;
   wire logic in_hiz;
   wire logic in_active;
   wire logic in_ring;

   assign in_hiz = (mode_d == slic_ctrl_pkg::MODE_HIGH_IMPEDANCE_FEED);
   assign in_active = (mode_d == slic_ctrl_pkg::MODE_ACTIVE);
   assign in_ring = (mode_d == slic_ctrl_pkg::MODE_RING);
   // detectors are off in power down, so nothing reaches the pin there
   assign detect_oe_d = ((in_hiz | in_active) & off_hook_sense)
                   | (in_ring & ring_trip_sense);

   // mode and line state
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         mode_q <= slic_ctrl_pkg::MODE_POWER_DOWN;
         thermal_q <= 1'b0;
         detect_oe_q <= 1'b0;
         line_hiz_q <= 1'b1;
         tx_en_q <= 1'b0;
         metering_q <= 1'b0;
         ring_bat_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         thermal_q <= thermal_d;
         detect_oe_q <= detect_oe_d;
         line_hiz_q <= (mode_d == slic_ctrl_pkg::MODE_POWER_DOWN);
         tx_en_q <= in_active;
         metering_q <= in_active & metering_enable_sel;
         ring_bat_q <= in_ring;
      end
   end

   // ---------------------------------------------------------------
   // polarity ramp
   // ---------------------------------------------------------------
   polarity_ramp_if ramp_bus ();
   logic target_rev_q;

   // polarity is ignored outside active and ring, so the line holds its last sense
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         target_rev_q <= 1'b0;
      end else if (in_active || in_ring) begin
         target_rev_q <= polarity_sel;
      end
   end

   assign ramp_bus.target_reversed = target_rev_q;

   polarity_ramp u_ramp (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .ramp(ramp_bus.gen)
   );

   // ---------------------------------------------------------------
   // converter gate drive
   // ---------------------------------------------------------------
   logic [slic_ctrl_pkg::OSC_CNT_W-1:0] osc_cnt_q;
   logic osc_q;
   logic gate_q;
   logic detect_pin_q;
   wire logic osc_wrap;
   wire logic switch_clk;
   wire logic gate_d;

   assign osc_wrap = (osc_cnt_q ==
      slic_ctrl_pkg::OSC_CNT_W'(slic_ctrl_pkg::OSC_HALF_CYCLES - 1));
   // supply-tied pin selects the internal oscillator
   assign switch_clk = clk_tied_supply ? osc_q : conv_clk_in;
   // gate only pulses while battery needs topping up; ground-tied pin kills it
   assign gate_d = ~clk_tied_ground & battery_low & switch_clk;

   // oscillator and gate
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         osc_cnt_q <= '0;
         osc_q <= 1'b0;
         gate_q <= 1'b0;
         detect_pin_q <= 1'b0;
      end else begin
         osc_cnt_q <= osc_wrap ? '0 : osc_cnt_q + 1'b1;
         osc_q <= osc_wrap ? ~osc_q : osc_q;
         gate_q <= gate_d;
         detect_pin_q <= 1'b0;                                    // open drain only pulls low
      end
   end

   assign loop_detect_n_o = detect_pin_q;
   assign loop_detect_n_oe = detect_oe_q;
   assign op_mode = mode_q;
   assign line_terminals_hiz = line_hiz_q;
   assign transmission_en = tx_en_q;
   assign metering_pulse = metering_q;
   assign ring_battery_sel = ring_bat_q;
   assign polarity_level = ramp_bus.level;
   assign polarity_settled = ramp_bus.settled;
   assign thermal_shutdown = thermal_q;
   assign gate_drive = gate_q;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   a_shutdown_decode: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      (!line_shutdown_n && !metering_enable_sel && !feed_enable_sel)
         |=> (op_mode == slic_ctrl_pkg::MODE_POWER_DOWN) && line_terminals_hiz)
      else $error("power down not selected");

   a_hiz_decode: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      (line_shutdown_n && !metering_enable_sel && !feed_enable_sel && !thermal_d)
         |=> op_mode == slic_ctrl_pkg::MODE_HIGH_IMPEDANCE_FEED)
      else $error("high impedance feed not selected");

   a_active_meter: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      (feed_enable_sel && !thermal_d) |=> (op_mode == slic_ctrl_pkg::MODE_ACTIVE)
         && transmission_en && (metering_pulse == $past(metering_enable_sel)))
      else $error("active mode or metering wrong");

   a_ring_decode: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      (line_shutdown_n && metering_enable_sel && !feed_enable_sel && !thermal_d)
         |=> (op_mode == slic_ctrl_pkg::MODE_RING) && ring_battery_sel)
      else $error("ring mode or ring battery not selected");

   a_shutdown_no_detect: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      (op_mode == slic_ctrl_pkg::MODE_POWER_DOWN) |-> !loop_detect_n_oe && !transmission_en)
      else $error("detect or transmission active in power down");

   a_hiz_offhook: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      (in_hiz && off_hook_sense) |=> loop_detect_n_oe && !loop_detect_n_o)
      else $error("off-hook not signalled in high impedance feed");

   a_ring_trip: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      (in_ring && ring_trip_sense) |=> loop_detect_n_oe)
      else $error("ring trip not signalled");

   a_thermal_force: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      over_temp |=> thermal_shutdown && (op_mode == slic_ctrl_pkg::MODE_POWER_DOWN))
      else $error("overtemperature did not force power down");

   a_thermal_resume: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      (thermal_shutdown && !over_temp && below_hysteresis) |=> !thermal_shutdown)
      else $error("thermal shutdown did not release");

   a_gate_ground_off: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      clk_tied_ground |=> !gate_drive)
      else $error("gate driven with clock pin grounded");

   a_gate_follows_clk: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      (!clk_tied_ground && !clk_tied_supply && battery_low) |=> gate_drive == $past(conv_clk_in))
      else $error("gate not following converter clock");

endmodule // slic_mode_control

// ### test/line_card_model.sv
// line card controller model that drives the mode pins of the line interface
`timescale 1ns/1ps
module line_card_model #(
   parameter int RING_HALF = 20
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [3:0] cmd_pins,
   input wire logic ring_req,
   input wire logic loop_detect_n,
   output logic line_shutdown_n,
   output logic metering_enable_sel,
   output logic feed_enable_sel,
   output logic polarity_sel,
   output logic trip_seen
);
   logic [1:0] detect_sync_q;
   logic [7:0] ring_cnt_q;
   logic ring_pol_q;
   logic ring_wrap;
   logic ringing;

   // ---------------------------------------------------------------
   // detect synchroniser and ring cadence
   // ---------------------------------------------------------------
   assign ring_wrap = (ring_cnt_q == 8'(RING_HALF - 1));
   // detect is asynchronous to us, so two flops before any decision
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         detect_sync_q <= 2'h0;
         ring_cnt_q <= 8'h00;
         ring_pol_q <= 1'h0;
         trip_seen <= 1'h0;
      end else begin
         detect_sync_q <= {detect_sync_q[0], ~loop_detect_n};
         trip_seen <= ring_req & (trip_seen | detect_sync_q[1]);
         ring_cnt_q <= ring_wrap ? 8'h00 : ring_cnt_q + 8'h01;
         ring_pol_q <= ring_pol_q ^ ring_wrap;
      end
   end

   // pin drive: a trip ends the burst and selects active normal
   assign ringing = ring_req & ~trip_seen;
   assign {line_shutdown_n, metering_enable_sel, feed_enable_sel, polarity_sel} =
      ringing ? {3'h6, ring_pol_q} : (ring_req ? 4'hA : cmd_pins);
endmodule // line_card_model

// ### test/slic_mode_control_tb.sv
// self-checking testbench of the line interface mode control
`timescale 1ns/1ps
module slic_mode_control_tb;
   logic ref_clk = 1'h0;
   logic reset_n = 1'h0;
   logic [3:0] cmd_pins = 4'h0;
   logic ring_req = 1'h0;
   logic off_hook_sense = 1'h0, ring_trip_sense = 1'h0, over_temp = 1'h0;
   logic below_hysteresis = 1'h0, conv_clk_in = 1'h0, conv_run = 1'h0;
   logic clk_tied_supply = 1'h0, clk_tied_ground = 1'h0, battery_low = 1'h0;
   logic line_shutdown_n, metering_enable_sel, feed_enable_sel, polarity_sel, trip_seen;
   logic loop_detect_n_o, loop_detect_n_oe, line_terminals_hiz, transmission_en;
   logic metering_pulse, ring_battery_sel, polarity_settled, thermal_shutdown, gate_drive;
   logic [slic_ctrl_pkg::RAMP_W-1:0] polarity_level;
   slic_ctrl_pkg::op_mode_t op_mode, e;
   int mismatches = 0;
   int samples_checked = 0;
   int conv_cnt = 0;
   int i;
   int r;
   logic saw_low;
   // open-drain detect with its external pull-up
   wire loop_detect_n = loop_detect_n_oe ? loop_detect_n_o : 1'h1;

   always #20 ref_clk = ~ref_clk;
   // external converter clock, about 125 kHz square
   always @(posedge ref_clk) begin
      if (conv_run) begin
         conv_cnt <= (conv_cnt == slic_ctrl_pkg::OSC_HALF_CYCLES - 1) ? 0 : conv_cnt + 1;
         if (conv_cnt == slic_ctrl_pkg::OSC_HALF_CYCLES - 1) conv_clk_in <= ~conv_clk_in;
      end
   end

   line_card_model i_line_card_model (.ref_clk(ref_clk), .reset_n(reset_n),
      .cmd_pins(cmd_pins), .ring_req(ring_req), .loop_detect_n(loop_detect_n),
      .line_shutdown_n(line_shutdown_n), .metering_enable_sel(metering_enable_sel),
      .feed_enable_sel(feed_enable_sel), .polarity_sel(polarity_sel), .trip_seen(trip_seen));
   slic_mode_control i_slic_mode_control (.ref_clk(ref_clk), .reset_n(reset_n),
      .line_shutdown_n(line_shutdown_n), .metering_enable_sel(metering_enable_sel),
      .feed_enable_sel(feed_enable_sel), .polarity_sel(polarity_sel),
      .off_hook_sense(off_hook_sense), .ring_trip_sense(ring_trip_sense),
      .over_temp(over_temp), .below_hysteresis(below_hysteresis), .conv_clk_in(conv_clk_in),
      .clk_tied_supply(clk_tied_supply), .clk_tied_ground(clk_tied_ground),
      .battery_low(battery_low), .loop_detect_n_o(loop_detect_n_o),
      .loop_detect_n_oe(loop_detect_n_oe), .op_mode(op_mode),
      .line_terminals_hiz(line_terminals_hiz), .transmission_en(transmission_en),
      .metering_pulse(metering_pulse), .ring_battery_sel(ring_battery_sel),
      .polarity_level(polarity_level), .polarity_settled(polarity_settled),
      .thermal_shutdown(thermal_shutdown), .gate_drive(gate_drive));

   // ---------------------------------------------------------------
   // access tasks
   // ---------------------------------------------------------------
   task automatic tick;
      @(posedge ref_clk);
      #1;
   endtask
   // pins taken at one edge, answer settled just after the next
   task automatic drive(input logic [3:0] p, input logic off, input logic ot, input logic bh);
      @(posedge ref_clk);
      cmd_pins <= p;
      off_hook_sense <= off;
      over_temp <= ot;
      below_hysteresis <= bh;
      tick();
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic give_up;
      mismatches++;
      $display("unexpected at %0t: wait ran out", $time);
      test_done();
   endtask
   // bounded wait; the ramp takes 255 steps of four cycles
   task automatic wait_level(input logic [7:0] exp);
      int n;
      n = 0;
      while (polarity_level !== exp) begin
         if (n == 1200) give_up();
         tick();
         n++;
      end
   endtask
   // settle a few cycles first so a strap change is not counted as a rise
   task automatic gate_rises(input logic run, input logic sup, input logic gnd,
                             input logic bat, output int rises);
      logic prev;
      @(posedge ref_clk);
      conv_run <= run;
      clk_tied_supply <= sup;
      clk_tied_ground <= gnd;
      battery_low <= bat;
      repeat (3) tick();
      rises = 0;
      prev = gate_drive;
      repeat (400) begin
         tick();
         if (prev === 1'h0 && gate_drive === 1'h1) rises++;
         prev = gate_drive;
      end
   endtask
   // expected mode from {shutdown_n, metering, feed, polarity}
   function automatic slic_ctrl_pkg::op_mode_t exp_mode(input logic [3:0] p);
      if (p[1]) return slic_ctrl_pkg::MODE_ACTIVE;
      if (p[3] && p[2]) return slic_ctrl_pkg::MODE_RING;
      if (p[3]) return slic_ctrl_pkg::MODE_HIGH_IMPEDANCE_FEED;
      return slic_ctrl_pkg::MODE_POWER_DOWN;
   endfunction

   // ---------------------------------------------------------------
   // test sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (5) tick();
      check(op_mode, slic_ctrl_pkg::MODE_POWER_DOWN);
      check(line_terminals_hiz, 1'h1);
      check(polarity_level, slic_ctrl_pkg::RAMP_NORMAL);
      @(posedge ref_clk);
      reset_n <= 1'h1;
      // every pin code, with and without off-hook
      for (i = 0; i < 32; i++) begin
         e = exp_mode(i[3:0]);
         drive(i[3:0], i[4], 1'h0, 1'h0);
         check(op_mode, e);
         check(line_terminals_hiz, e == slic_ctrl_pkg::MODE_POWER_DOWN);
         check(transmission_en, e == slic_ctrl_pkg::MODE_ACTIVE);
         check(metering_pulse, e == slic_ctrl_pkg::MODE_ACTIVE && i[2]);
         check(ring_battery_sel, e == slic_ctrl_pkg::MODE_RING);
         check(loop_detect_n, !(i[4] && (e == slic_ctrl_pkg::MODE_ACTIVE
            || e == slic_ctrl_pkg::MODE_HIGH_IMPEDANCE_FEED)));
      end
      $display("test decode done");
      drive(4'hA, 1'h0, 1'h1, 1'h0);
      check(op_mode, slic_ctrl_pkg::MODE_POWER_DOWN);
      check(thermal_shutdown, 1'h1);
      drive(4'hA, 1'h1, 1'h0, 1'h0);
      check(op_mode, slic_ctrl_pkg::MODE_POWER_DOWN);
      check(loop_detect_n, 1'h1);
      drive(4'hA, 1'h0, 1'h0, 1'h1);
      check(op_mode, slic_ctrl_pkg::MODE_ACTIVE);
      check(thermal_shutdown, 1'h0);
      $display("test thermal done");
      wait_level(slic_ctrl_pkg::RAMP_NORMAL);
      drive(4'hB, 1'h0, 1'h0, 1'h1);
      repeat (8) tick();
      check(polarity_settled, 1'h0);
      check(polarity_level <= 8'h03, 1'h1);
      wait_level(slic_ctrl_pkg::RAMP_REVERSED);
      tick();
      check(polarity_settled, 1'h1);
      $display("test ramp done");
      @(posedge ref_clk);
      ring_req <= 1'h1;
      repeat (4) tick();
      check(op_mode, slic_ctrl_pkg::MODE_RING);
      check(ring_battery_sel, 1'h1);
      @(posedge ref_clk);
      ring_trip_sense <= 1'h1;
      saw_low = 1'h0;
      for (i = 0; i < 20 && op_mode !== slic_ctrl_pkg::MODE_ACTIVE; i++) begin
         tick();
         if (loop_detect_n === 1'h0) saw_low = 1'h1;
      end
      check(saw_low, 1'h1);
      check(op_mode, slic_ctrl_pkg::MODE_ACTIVE);
      check(trip_seen, 1'h1);
      check(ring_battery_sel, 1'h0);
      // the trip wait is bounded: running out ends the run as a failure
      if (op_mode !== slic_ctrl_pkg::MODE_ACTIVE) give_up();
      @(posedge ref_clk);
      ring_req <= 1'h0;
      ring_trip_sense <= 1'h0;
      $display("test ring done");
      gate_rises(1'h1, 1'h0, 1'h0, 1'h1, r);
      check(r, 2);
      gate_rises(1'h1, 1'h0, 1'h0, 1'h0, r);
      check(r, 0);
      gate_rises(1'h1, 1'h0, 1'h1, 1'h1, r);
      check(r, 0);
      gate_rises(1'h0, 1'h1, 1'h0, 1'h1, r);
      check(r, 2);
      $display("test gate done");
      test_done();
   end
endmodule // slic_mode_control_tb
